// *** include/clkrst_pkg.sv ***
package clkrst_pkg;

    // Multiplier range for the clock multiplier
    localparam logic [3:0] MULT_MIN        = 4'h4;
    localparam logic [3:0] MULT_MAX        = 4'hF;
    localparam logic [3:0] MULT_RESET      = 4'h4;

    // Reset stretch length, counted on the reference clock
    localparam int         STRETCH_CYCLES  = 256;
    localparam logic [8:0] STRETCH_LAST    = 9'(STRETCH_CYCLES - 1);

    // Lock wait after the synchronised lock input rises with the multiplier on, in cycles of REF_CLK_I
    localparam int         LOCK_CYCLES     = 64;
    localparam logic [6:0] LOCK_LAST       = 7'(LOCK_CYCLES - 1);

    // Core clock ceilings, in kHz, per device variant
    localparam int         CORE_MAX_KHZ_LO = 147456;
    localparam int         CORE_MAX_KHZ_HI = 159744;
    localparam int         REF_KHZ         = 100000;

    // Divider reset values
    localparam logic [7:0] DIV_RESET       = 8'h01;

    typedef struct packed {
        logic [3:0] mult;
        logic       pll_enable;
        logic       select_pll;
        logic [7:0] core_div;
        logic [7:0] spdif_div;
        logic [7:0] adc_div;
        logic [7:0] mclk_div;
    } clk_cfg_t;

    typedef struct packed {
        logic core;
        logic spdif;
        logic adc;
        logic mclk;
    } clk_en_t;

    typedef struct packed {
        logic pll_supply_rail_ok;
        logic core_supply_rail_ok;
        logic pwm_supply_rail_ok;
    } supply_t;

endpackage

// *** rtl/pll_clock_and_reset_gen.sv ***
// Behaviour
// - Multiplier factor limited to 4 through 15
// - Bypass to reference until configured and locked
// - Selected PLL clock times PWM and core
// - Divided enables for core, spdif, converter, mclk
// - All clock settings come from firmware controls
// - Reference forwarded to oscillator buffer output
// - Power-on pulse on each pll supply rise
// - Power-on reset drives reset output low
// - Brown-out on either rail drives reset low
// - Internal reset on external low or power-on
// - Counter stretches internal reset after release
// - Core rate from the requested multiplier checked against variant maximum
// - During reset: internal resets active, PLL off
// - Boot mode pins latched at reset release
`timescale 1ns/100ps
`default_nettype none

module pll_clock_and_reset_gen
    import clkrst_pkg::*;
#(
    parameter bit FAST_VARIANT = 1'b0
) (
    input  wire logic                REF_CLK_I,
    input  wire logic                SRST_I,
    input  wire clkrst_pkg::clk_cfg_t CFG_I,
    input  wire clkrst_pkg::supply_t SUPPLY_I,
    input  wire logic                EXT_RESET_IN_N_I,
    input  wire logic                PLL_LOCK_RAW_I,
    input  wire logic [3:0]          BOOT_PINS_I,
    output logic                     OSCILLATOR_BUFFER_OUT_O,
    output logic                     RESET_OUTPUT_LOW_O,
    output logic                     INT_RESET_O,
    output logic                     PLL_ENABLE_O,
    output logic [3:0]               PLL_MULT_O,
    output logic                     PLL_LOCKED_O,
    output logic                     PLL_SELECTED_O,
    output logic                     CFG_ERROR_O,
    output clkrst_pkg::clk_en_t      CLK_EN_O,
    output logic [3:0]               BOOT_MODE_O,
    output logic                     BOOT_START_O
);
    import clkrst_pkg::*;

    typedef struct packed {
        logic [2:0] ext_sync;
        logic [2:0] por_sync;
        logic [2:0] cbo_sync;
        logic [2:0] pbo_sync;
        logic [2:0] lock_sync;
        logic       ext_level;
        logic       pll_ok;
        logic       cbo_ok;
        logic       pbo_ok;
        logic       lock_level;
        logic       por_pulse;
        logic       int_reset;
        logic [8:0] stretch;
        logic [6:0] lock_wait;
        logic       locked;
        logic       pll_on;
        logic [3:0] mult;
        logic       sel_pll;
        logic       cfg_error;
        logic [7:0] cnt_core;
        logic [7:0] cnt_spdif;
        logic [7:0] cnt_adc;
        logic [7:0] cnt_mclk;
        clk_en_t    en;
        logic [3:0] boot_mode;
        logic       boot_start;
    } state_t;

    state_t state;
    state_t next_state;
    logic   mult_ok;
    logic   rate_ok;
    logic   reset_any;
    int     core_khz;

    // Oscillator buffer is a straight pass of the reference
    assign OSCILLATOR_BUFFER_OUT_O = REF_CLK_I;

    always_comb begin
        next_state = state;
        // Three-stage sync; a change counts once stages two and three agree
        next_state.ext_sync  = {state.ext_sync[1:0], EXT_RESET_IN_N_I};
        next_state.por_sync  = {state.por_sync[1:0], SUPPLY_I.pll_supply_rail_ok};
        next_state.cbo_sync  = {state.cbo_sync[1:0], SUPPLY_I.core_supply_rail_ok};
        next_state.pbo_sync  = {state.pbo_sync[1:0], SUPPLY_I.pwm_supply_rail_ok};
        next_state.lock_sync = {state.lock_sync[1:0], PLL_LOCK_RAW_I};
        if (state.ext_sync[2] == state.ext_sync[1]) begin
            next_state.ext_level = state.ext_sync[2];
        end
        if (state.por_sync[2] == state.por_sync[1]) begin
            next_state.pll_ok = state.por_sync[2];
        end
        if (state.cbo_sync[2] == state.cbo_sync[1]) begin
            next_state.cbo_ok = state.cbo_sync[2];
        end
        if (state.pbo_sync[2] == state.pbo_sync[1]) begin
            next_state.pbo_ok = state.pbo_sync[2];
        end
        if (state.lock_sync[2] == state.lock_sync[1]) begin
            next_state.lock_level = state.lock_sync[2];
        end

        // Pulse on every rise of the pll supply, including after a droop
        next_state.por_pulse = next_state.pll_ok && !state.pll_ok;

        // Supply below threshold also counts, so a droop holds the pulse source
        reset_any = !state.ext_level || state.por_pulse || !state.pll_ok;

        if (reset_any) begin
            next_state.int_reset = 1'b1;
            next_state.stretch   = '0;
        end else if (state.int_reset) begin
            if (state.stretch == STRETCH_LAST) begin
                next_state.int_reset = 1'b0;
            end else begin
                next_state.stretch = state.stretch + 9'h001;
            end
        end

        // Boot pins caught at the stretch release
        next_state.boot_start = 1'b0;
        if (state.int_reset && !next_state.int_reset) begin
            next_state.boot_mode  = BOOT_PINS_I;
            next_state.boot_start = 1'b1;
        end

        mult_ok  = (CFG_I.mult >= MULT_MIN) && (CFG_I.mult <= MULT_MAX);
        core_khz = (REF_KHZ * int'(CFG_I.mult)) / int'(CFG_I.core_div == 8'h00 ? 8'h01
                                                                             : CFG_I.core_div);
        rate_ok  = core_khz <= (FAST_VARIANT ? CORE_MAX_KHZ_HI : CORE_MAX_KHZ_LO);
        next_state.cfg_error = !mult_ok || !rate_ok;

        // Taken on the edge that raises reset, so the multiplier is never on in reset
        if (next_state.int_reset) begin
            // Multiplier held off and bypass forced during reset
            next_state.pll_on    = 1'b0;
            next_state.sel_pll   = 1'b0;
            next_state.locked    = 1'b0;
            next_state.lock_wait = '0;
            next_state.mult      = MULT_RESET;
        end else begin
            // Settings only ever taken from firmware controls
            next_state.pll_on = CFG_I.pll_enable && mult_ok;
            if (!state.pll_on) begin
                next_state.mult = mult_ok ? CFG_I.mult : state.mult;
            end
            if (!state.pll_on || !state.lock_level) begin
                next_state.lock_wait = '0;
                next_state.locked    = 1'b0;
            end else if (state.lock_wait == LOCK_LAST) begin
                next_state.locked = 1'b1;
            end else begin
                next_state.lock_wait = state.lock_wait + 7'h01;
            end
            // Switch only at a core divider boundary so the core enable is not cut short
            if (state.cnt_core == 8'h00) begin
                next_state.sel_pll = CFG_I.select_pll && state.locked && rate_ok;
            end
        end

        next_state.en = '0;
        if (state.int_reset) begin
            next_state.cnt_core  = '0;
            next_state.cnt_spdif = '0;
            next_state.cnt_adc   = '0;
            next_state.cnt_mclk  = '0;
        end else begin
            // Enables tick on the reference clock, whichever tree is selected
            if (state.cnt_core + 8'h01 >= CFG_I.core_div) begin
                next_state.cnt_core = '0;
                next_state.en.core  = 1'b1;
            end else begin
                next_state.cnt_core = state.cnt_core + 8'h01;
            end
            if (state.cnt_spdif + 8'h01 >= CFG_I.spdif_div) begin
                next_state.cnt_spdif = '0;
                next_state.en.spdif  = 1'b1;
            end else begin
                next_state.cnt_spdif = state.cnt_spdif + 8'h01;
            end
            if (state.cnt_adc + 8'h01 >= CFG_I.adc_div) begin
                next_state.cnt_adc = '0;
                next_state.en.adc  = 1'b1;
            end else begin
                next_state.cnt_adc = state.cnt_adc + 8'h01;
            end
            if (state.cnt_mclk + 8'h01 >= CFG_I.mclk_div) begin
                next_state.cnt_mclk = '0;
                next_state.en.mclk  = 1'b1;
            end else begin
                next_state.cnt_mclk = state.cnt_mclk + 8'h01;
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            state            <= '0;
            state.int_reset  <= 1'b1;
            state.ext_sync   <= 3'h7;
            // Core and pwm rail syncs start at their ok level, so no false brown-out after reset
            state.cbo_sync   <= 3'h7;
            state.pbo_sync   <= 3'h7;
            state.ext_level  <= 1'b1;
            state.cbo_ok     <= 1'b1;
            state.pbo_ok     <= 1'b1;
            state.mult       <= MULT_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Power-on pulse or either brown-out pulls the output pin low
    assign RESET_OUTPUT_LOW_O = !(state.por_pulse || !state.pll_ok
                                  || !state.cbo_ok || !state.pbo_ok);
    assign INT_RESET_O    = state.int_reset;
    assign PLL_ENABLE_O   = state.pll_on;
    assign PLL_MULT_O     = state.mult;
    assign PLL_LOCKED_O   = state.locked;
    assign PLL_SELECTED_O = state.sel_pll;
    assign CFG_ERROR_O    = state.cfg_error;
    assign CLK_EN_O       = state.en;
    assign BOOT_MODE_O    = state.boot_mode;
    assign BOOT_START_O   = state.boot_start;

endmodule // pll_clock_and_reset_gen

`default_nettype wire

// *** tb/board_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module board_model
    import clkrst_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              pll_enable_i,
    input  wire logic [2:0]        rails_i,
    input  wire logic              ext_n_i,
    output var clkrst_pkg::supply_t supply_o,
    output logic                   ext_reset_n_o,
    output logic                   lock_raw_o
);
    logic [4:0] settle = 5'h00;
    assign supply_o = supply_t'(rails_i);
    assign ext_reset_n_o = ext_n_i;
    assign lock_raw_o = (settle == 5'h14);
    // Loop settles slowly; lock is lost at once when disabled
    always @(negedge clk_i) begin
        settle <= pll_enable_i ? settle + {4'h0, settle != 5'h14} : 5'h00;
    end
endmodule // board_model
`default_nettype wire

// *** tb/clkrst_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module clkrst_asserts
    import clkrst_pkg::*;
(
    input wire logic                REF_CLK_I,
    input wire logic                SRST_I,
    input wire clkrst_pkg::supply_t SUPPLY_I,
    input wire logic                EXT_RESET_IN_N_I,
    input wire logic [3:0]          BOOT_PINS_I,
    input wire logic                RESET_OUTPUT_LOW_O,
    input wire logic                INT_RESET_O,
    input wire logic                PLL_ENABLE_O,
    input wire logic [3:0]          PLL_MULT_O,
    input wire logic                PLL_LOCKED_O,
    input wire logic                PLL_SELECTED_O,
    input wire logic                CFG_ERROR_O,
    input wire logic [3:0]          BOOT_MODE_O,
    input wire logic                BOOT_START_O
);
    import clkrst_pkg::*;

    logic [8:0] quiet;

    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SRST_I);

    // Raw quiet time; the design adds its input sync delay on top
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I || !EXT_RESET_IN_N_I || !(&SUPPLY_I)) begin
            quiet <= '0;
        end else if (quiet != 9'h1FF) begin
            quiet <= quiet + 9'h001;
        end
    end

    property p_mult;
        PLL_ENABLE_O |-> PLL_MULT_O >= MULT_MIN;
    endproperty
    a_mult: assert property (p_mult) else $error("multiplier below range");
    property p_bypass;
        $rose(PLL_SELECTED_O) |-> PLL_LOCKED_O && !CFG_ERROR_O;
    endproperty
    a_bypass: assert property (p_bypass) else $error("switched before lock");
    // Four sync edges, then the output pin follows the brown-out flag
    property p_brown;
        !SUPPLY_I.core_supply_rail_ok [*5] |-> !RESET_OUTPUT_LOW_O;
    endproperty
    a_brown: assert property (p_brown) else $error("reset out high on brown-out");
    // Four sync edges plus one for the reset register itself
    property p_ext;
        !EXT_RESET_IN_N_I [*6] |-> INT_RESET_O;
    endproperty
    a_ext: assert property (p_ext) else $error("no internal reset");
    property p_stretch;
        $fell(INT_RESET_O) |-> quiet inside {[9'h100:9'h10A]};
    endproperty
    a_stretch: assert property (p_stretch) else $error("stretch length wrong");
    // Boot strobe rises on the same edge that ends the stretch
    property p_boot;
        $fell(INT_RESET_O) |-> BOOT_START_O ##1 !BOOT_START_O;
    endproperty
    a_boot: assert property (p_boot) else $error("boot start pulse wrong");
    property p_mode;
        BOOT_START_O |-> BOOT_MODE_O == BOOT_PINS_I;
    endproperty
    a_mode: assert property (p_mode) else $error("boot mode not latched");
    property p_off;
        INT_RESET_O |-> !PLL_ENABLE_O && !PLL_SELECTED_O;
    endproperty
    a_off: assert property (p_off) else $error("multiplier on in reset");
    property p_frozen;
        PLL_ENABLE_O && $past(PLL_ENABLE_O) |-> $stable(PLL_MULT_O);
    endproperty
    a_frozen: assert property (p_frozen) else $error("factor moved while on");
    c_release: cover property ($fell(INT_RESET_O));
    c_select: cover property ($rose(PLL_SELECTED_O));
    c_error: cover property ($rose(CFG_ERROR_O));
endmodule // clkrst_asserts
bind pll_clock_and_reset_gen clkrst_asserts clkrst_asserts_i (.REF_CLK_I, .SRST_I, .SUPPLY_I,
    .EXT_RESET_IN_N_I, .BOOT_PINS_I, .RESET_OUTPUT_LOW_O, .INT_RESET_O, .PLL_ENABLE_O,
    .PLL_MULT_O, .PLL_LOCKED_O, .PLL_SELECTED_O, .CFG_ERROR_O, .BOOT_MODE_O, .BOOT_START_O);
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
    import clkrst_pkg::*;
    logic clk, srst, ext_n, osc, rst_out_n, int_rst, pll_en, locked, selected, cfg_err;
    logic boot_start, ext_reset_n, lock_raw;
    logic [2:0] rails;
    logic [3:0] mult, boot_mode;
    logic [3:0] boot_pins = 4'hA;
    clk_cfg_t cfg;
    clk_en_t clk_en;
    supply_t supply;
    int fail_count = 0, cmp_count = 0, cycles = 0, n;
    int n_core, n_spdif, n_adc;
    pll_clock_and_reset_gen pll_clock_and_reset_gen_i (
        .REF_CLK_I(clk), .SRST_I(srst), .CFG_I(cfg), .SUPPLY_I(supply),
        .EXT_RESET_IN_N_I(ext_reset_n), .PLL_LOCK_RAW_I(lock_raw), .BOOT_PINS_I(boot_pins),
        .OSCILLATOR_BUFFER_OUT_O(osc), .RESET_OUTPUT_LOW_O(rst_out_n), .INT_RESET_O(int_rst),
        .PLL_ENABLE_O(pll_en), .PLL_MULT_O(mult), .PLL_LOCKED_O(locked),
        .PLL_SELECTED_O(selected), .CFG_ERROR_O(cfg_err), .CLK_EN_O(clk_en),
        .BOOT_MODE_O(boot_mode), .BOOT_START_O(boot_start));
    board_model board_model_i (.clk_i(clk), .pll_enable_i(pll_en), .rails_i(rails),
        .ext_n_i(ext_n), .supply_o(supply), .ext_reset_n_o(ext_reset_n), .lock_raw_o(lock_raw));
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wait_release(output int k);
        for (k = 0; k < 600 && int_rst !== 1'b0; k++) tick(1);
    endtask
    task automatic t_boot;
        wait_release(n);
        `CHK(n inside {[256:266]}, 1'b1)
        `CHK(rst_out_n, 1'b1)
        `CHK(selected, 1'b0)
        // Boot strobe rises on the edge that ends the stretch
        `CHK(boot_start, 1'b1)
        `CHK(boot_mode, 4'hA)
        // Buffer output looked at in both clock phases
        @(posedge clk);
        #1;
        `CHK(osc, 1'b1)
        tick(1);
        `CHK(osc, 1'b0)
        `CHK(boot_start, 1'b0)
    endtask
    task automatic t_pll;
        cfg.mult = 4'h3;
        cfg.pll_enable = 1'b1;
        tick(5);
        `CHK(pll_en, 1'b0)
        `CHK(cfg_err, 1'b1)
        cfg.mult = 4'hF;
        cfg.core_div = 8'h0B;
        cfg.spdif_div = 8'h02;
        cfg.adc_div = 8'h04;
        cfg.mclk_div = 8'h04;
        cfg.select_pll = 1'b1;
        tick(5);
        `CHK(pll_en, 1'b1)
        `CHK(selected, 1'b0)
        for (n = 0; n < 200 && locked !== 1'b1; n++) tick(1);
        `CHK(locked, 1'b1)
        tick(20);
        `CHK(selected, 1'b1)
        // 44 cycles hold a whole number of periods of every divider
        n = 0;
        n_core = 0;
        n_spdif = 0;
        n_adc = 0;
        repeat (44) begin
            tick(1);
            n += (clk_en.mclk === 1'b1);
            n_core += (clk_en.core === 1'b1);
            n_spdif += (clk_en.spdif === 1'b1);
            n_adc += (clk_en.adc === 1'b1);
        end
        `CHK(n, 11)
        `CHK(n_core, 4)
        `CHK(n_spdif, 22)
        `CHK(n_adc, 11)
        cfg.mult = 4'h5;
        tick(6);
        `CHK(mult, 4'hF)
        cfg.mult = 4'hF;
        cfg.core_div = 8'h0A;
        tick(6);
        `CHK(cfg_err, 1'b1)
        cfg.core_div = 8'h0B;
    endtask
    task automatic t_faults;
        rails = 3'b101;
        tick(6);
        `CHK(rst_out_n, 1'b0)
        rails = 3'b110;
        tick(6);
        `CHK(rst_out_n, 1'b0)
        rails = 3'b011;
        tick(6);
        `CHK(rst_out_n, 1'b0)
        rails = 3'h7;
        ext_n = 1'b0;
        tick(6);
        `CHK(int_rst, 1'b1)
        `CHK(pll_en, 1'b0)
        ext_n = 1'b1;
        tick(100);
        ext_n = 1'b0;
        boot_pins = 4'h5;
        tick(6);
        ext_n = 1'b1;
        wait_release(n);
        `CHK(n inside {[256:266]}, 1'b1)
        `CHK(boot_start, 1'b1)
        `CHK(boot_mode, 4'h5)
    endtask
    task automatic wrap_up;
        $display("Mismatches %0d, comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run needs about 830 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        srst = 1'b1;
        cfg = '0;
        cfg.mult = 4'h4;
        rails = 3'h7;
        ext_n = 1'b1;
        tick(2);
        srst = 1'b0;
        t_boot();
        t_pll();
        t_faults();
        wrap_up();
    end
endmodule // tb
`default_nettype wire
